// >>> loopback_bist_pkg.sv
`default_nettype none

package loopback_bist_pkg;

    // functional modes of the channel
    typedef enum logic [1:0] {
        MODE_BASIC = 2'b00,
        MODE_PIPE  = 2'b01,
        MODE_OTHER = 2'b10
    } func_mode_t;

    // loopback paths chosen by configuration
    typedef enum logic [2:0] {
        LPBK_NONE       = 3'b000,
        LPBK_SERIAL     = 3'b001,
        LPBK_PARALLEL   = 3'b010,
        LPBK_REV_SERIAL = 3'b011,
        LPBK_REV_PRECDR = 3'b100,
        LPBK_PIPE_REVP  = 3'b101
    } lpbk_t;

    // pattern choice for generator and verifier
    typedef enum logic {
        PRBS_7  = 1'b0,
        PRBS_10 = 1'b1
    } prbs_t;

    // receive fifo depths in words
    localparam int FIFO_DEPTH_PIPE  = 8;
    localparam int FIFO_DEPTH_OTHER = 4;
    localparam int FIFO_MAX_DEPTH   = 8;
    localparam int FIFO_PTR_W       = 3;

    // lfsr lengths and feedback taps (bit index of x^n is n-1)
    localparam int PRBS_STATE_W = 10;
    localparam int PRBS7_LEN    = 7;
    localparam int PRBS7_TAP_A  = 6;
    localparam int PRBS7_TAP_B  = 5;
    localparam int PRBS10_TAP_A = 9;
    localparam int PRBS10_TAP_B = 6;
    localparam logic [9:0] PRBS_SEED = 10'h3ff;

    // basic mode line rates in Mbps
    localparam logic [12:0] SINGLE_RATE_MIN = 13'd600;
    localparam logic [12:0] SINGLE_RATE_MAX = 13'd3125;
    localparam logic [12:0] DOUBLE_RATE_MIN = 13'd1000;
    localparam logic [12:0] DOUBLE_RATE_MAX = 13'd6375;

    // consecutive good words before the verifier reports lock
    localparam int ALIGN_COUNT = 4;
    localparam int ALIGN_CNT_W = 3;

endpackage : loopback_bist_pkg

`default_nettype wire

// >>> transceiver_loopback_bist.sv
// Operation
// - rx fifo eight deep in pipe, else four
// - after fifo reset, write every cycle
// - five loopback paths; reverse parallel pipe only
// - serial loopback skips input buffer, never pipe
// - serial loopback enabled per channel at runtime
// - fabric data, or basic-mode internal prbs
// - prbs7 x7+x6+1 and prbs10 x10+x7+1
// - parallel loopback digital only, not retimed
// - parallel loopback basic double width only
// - parallel loopback sends bist, folds after coding
// - verifier compares returned words, flags errors
// - basic rates: single 600-3125, double 1000-6375
`default_nettype none

module transceiver_loopback_bist #(
    parameter int WORD_W = 20
) (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic [1:0]            func_mode,
    input  wire logic                  double_width,
    input  wire logic [12:0]           line_rate_mbps,
    input  wire logic [2:0]            lpbk_sel,
    input  wire logic                  serial_lpbk_en,
    input  wire logic                  bist_en,
    input  wire logic                  prbs_sel,
    input  wire logic                  rx_fifo_rst,
    input  wire logic [WORD_W-1:0]     tx_data,
    input  wire logic [WORD_W-1:0]     line_rx_word,
    output logic      [WORD_W-1:0]     line_tx_word,
    output logic      [WORD_W-1:0]     rx_data,
    output logic                       rx_data_valid,
    output logic                       bist_aligned,
    output logic                       bist_error,
    output logic                       cfg_illegal,
    output logic                       rate_error
);

    // the lfsr window must fit into one word
    if (WORD_W < loopback_bist_pkg::PRBS_STATE_W || WORD_W % 2 != 0) begin
        : g_bad_word_w
        $error("WORD_W must be even and at least 10");
    end

    // one word of prbs, oldest bit in bit 0; returns the word
    function automatic logic [WORD_W-1:0] prbs_word(
        input logic [9:0] seed,
        input logic       sel
    );
        logic [9:0]        s;
        logic              b;
        logic [WORD_W-1:0] w;
        s = seed;
        w = '0;
        for (int i = 0; i < WORD_W; i++) begin
            if (sel == loopback_bist_pkg::PRBS_10) begin
                b = s[loopback_bist_pkg::PRBS10_TAP_A]
                    ^ s[loopback_bist_pkg::PRBS10_TAP_B];
            end else begin
                b = s[loopback_bist_pkg::PRBS7_TAP_A]
                    ^ s[loopback_bist_pkg::PRBS7_TAP_B];
            end
            w[i] = b;
            s = {s[8:0], b};
        end
        return w;
    endfunction

    // lfsr state implied by the last ten bits of a word
    function automatic logic [9:0] word_to_state(
        input logic [WORD_W-1:0] w,
        input logic              sel
    );
        logic [9:0] s;
        for (int i = 0; i < loopback_bist_pkg::PRBS_STATE_W; i++) begin
            s[i] = w[WORD_W-1-i];
        end
        // prbs7 only uses the low seven stages
        if (sel == loopback_bist_pkg::PRBS_7) begin
            s[9:loopback_bist_pkg::PRBS7_LEN] = '0;
        end
        return s;
    endfunction

    // configuration decode
    wire logic is_pipe  = func_mode == loopback_bist_pkg::MODE_PIPE;
    wire logic is_basic = func_mode == loopback_bist_pkg::MODE_BASIC;

    wire logic serial_on = serial_lpbk_en && !is_pipe;

    // parallel only in basic double width
    wire logic par_ok = is_basic && double_width;

    wire logic revp_ok = is_pipe;

    // static path, dropped to none when not allowed
    wire logic sel_par   = lpbk_sel == loopback_bist_pkg::LPBK_PARALLEL;
    wire logic sel_revp  = lpbk_sel == loopback_bist_pkg::LPBK_PIPE_REVP;
    wire logic sel_rser  = lpbk_sel == loopback_bist_pkg::LPBK_REV_SERIAL;
    wire logic sel_rpre  = lpbk_sel == loopback_bist_pkg::LPBK_REV_PRECDR;
    wire logic sel_valid = lpbk_sel <= loopback_bist_pkg::LPBK_PIPE_REVP;
    wire logic sel_ser   = lpbk_sel == loopback_bist_pkg::LPBK_SERIAL;

    // resolved path flags; the enable pin owns serial
    wire logic par_on  = sel_par && par_ok;
    wire logic revp_on = sel_revp && revp_ok;
    wire logic rser_on = sel_rser && !serial_on;
    wire logic rpre_on = sel_rpre && !serial_on;

    // a requested path that this mode cannot give
    wire logic illegal_next = (sel_par && !par_ok) || (sel_revp && !revp_ok)
                              || !sel_valid || sel_ser
                              || (serial_lpbk_en && is_pipe);

    // line rate window per datapath width
    wire logic rate_bad_single = line_rate_mbps
                                 < loopback_bist_pkg::SINGLE_RATE_MIN
                                 || line_rate_mbps
                                 > loopback_bist_pkg::SINGLE_RATE_MAX;
    wire logic rate_bad_double = line_rate_mbps
                                 < loopback_bist_pkg::DOUBLE_RATE_MIN
                                 || line_rate_mbps
                                 > loopback_bist_pkg::DOUBLE_RATE_MAX;
    wire logic rate_bad = is_basic
                          && (double_width ? rate_bad_double
                                           : rate_bad_single);

    // generator drives tx in basic bist with serial loopback on, or parallel
    wire logic gen_on = (bist_en && is_basic && serial_on) || par_on;

    // generator state
    logic [9:0]        gen_state_reg;
    wire logic [WORD_W-1:0] gen_word = prbs_word(gen_state_reg, prbs_sel);
    wire logic [9:0]   gen_state_next = gen_on
                       ? word_to_state(gen_word, prbs_sel)
                       : loopback_bist_pkg::PRBS_SEED;

    // generator advances one word per cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gen_state_reg <= loopback_bist_pkg::PRBS_SEED;
        end else begin
            gen_state_reg <= gen_state_next;
        end
    end

    // single width leaves the upper half of fabric data unused
    wire logic [WORD_W-1:0] half_mask = double_width ? {WORD_W{1'b1}}
                            : {{(WORD_W/2){1'b0}}, {(WORD_W/2){1'b1}}};

    // pcs transmit word: generator or fabric
    wire logic [WORD_W-1:0] pcs_tx_word = gen_on ? gen_word
                                                 : (tx_data & half_mask);

    // retimed copies stand in for the serdes and the cdr stages
    logic [WORD_W-1:0] ser_loop_reg;
    logic [WORD_W-1:0] cdr_reg;
    logic [WORD_W-1:0] rx_fifo_out_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ser_loop_reg <= '0;
            cdr_reg      <= '0;
        end else begin
            ser_loop_reg <= pcs_tx_word;
            cdr_reg      <= line_rx_word;
        end
    end

    // serial fold passes serializer and deserializer
    // parallel fold is taken unretimed at pcs end
    wire logic [WORD_W-1:0] rx_src_word = par_on    ? pcs_tx_word
                                        : serial_on ? ser_loop_reg
                                        : line_rx_word;

    // reverse paths drive the line from the receive side
    // pre-cdr skips the recovery retime stage
    wire logic [WORD_W-1:0] tx_line_next = revp_on ? rx_fifo_out_reg
                                         : rser_on ? cdr_reg
                                         : rpre_on ? line_rx_word
                                         : pcs_tx_word;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_tx_word <= '0;
            cfg_illegal  <= 1'b0;
            rate_error   <= 1'b0;
        end else begin
            line_tx_word <= tx_line_next;
            cfg_illegal  <= illegal_next;
            rate_error   <= rate_bad;
        end
    end

    // verifier: self-synchronising, seeds from the previous word
    localparam int ALIGN_W = loopback_bist_pkg::ALIGN_CNT_W;
    logic [WORD_W-1:0]  chk_prev_reg;
    logic [ALIGN_W-1:0] chk_cnt_reg;
    localparam logic [ALIGN_W-1:0] ALIGN_LAST =
        ALIGN_W'(loopback_bist_pkg::ALIGN_COUNT);

    // expected word from the last received word
    wire logic [WORD_W-1:0] chk_expect =
        prbs_word(word_to_state(chk_prev_reg, prbs_sel), prbs_sel);
    wire logic chk_match = chk_expect == rx_src_word;
    wire logic chk_locked = chk_cnt_reg == ALIGN_LAST;

    // count good words until lock, reset on a miss before lock, hold on a miss after it
    wire logic [ALIGN_W-1:0] chk_cnt_next =
        !gen_on                 ? '0
        : !chk_match            ? (chk_locked ? chk_cnt_reg : '0)
        : chk_locked            ? chk_cnt_reg
        : chk_cnt_reg + ALIGN_W'(1);

    // mismatch after lock is a bit error
    wire logic err_next = gen_on && chk_locked && !chk_match;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chk_prev_reg <= '0;
            chk_cnt_reg  <= '0;
            bist_aligned <= 1'b0;
            bist_error   <= 1'b0;
        end else begin
            chk_prev_reg <= rx_src_word;
            chk_cnt_reg  <= chk_cnt_next;
            bist_aligned <= chk_cnt_next == ALIGN_LAST;
            bist_error   <= err_next;
        end
    end

    // receive phase-compensation fifo
    logic [WORD_W-1:0] fifo_mem [loopback_bist_pkg::FIFO_MAX_DEPTH];
    logic [loopback_bist_pkg::FIFO_PTR_W-1:0] wr_ptr_reg;
    logic [loopback_bist_pkg::FIFO_PTR_W-1:0] rd_ptr_reg;
    logic                                     rd_run_reg;
    localparam int PW = loopback_bist_pkg::FIFO_PTR_W;

    wire logic [PW-1:0] last_ptr = is_pipe
        ? PW'(loopback_bist_pkg::FIFO_DEPTH_PIPE - 1)
        : PW'(loopback_bist_pkg::FIFO_DEPTH_OTHER - 1);
    wire logic [PW-1:0] half_ptr = is_pipe
        ? PW'(loopback_bist_pkg::FIFO_DEPTH_PIPE / 2)
        : PW'(loopback_bist_pkg::FIFO_DEPTH_OTHER / 2);

    // write pointer steps every cycle once out of reset
    wire logic [PW-1:0] wr_ptr_next = rx_fifo_rst ? '0
        : (wr_ptr_reg == last_ptr) ? '0 : wr_ptr_reg + PW'(1);

    // reading starts half a fifo behind to absorb phase drift;
    // this spacing only holds if the clocks stay locked
    wire logic rd_start = !rd_run_reg && (wr_ptr_reg == half_ptr);
    wire logic rd_go    = rd_run_reg || rd_start;
    wire logic [PW-1:0] rd_ptr_next = rx_fifo_rst ? '0
        : !rd_go ? rd_ptr_reg
        : (rd_ptr_reg == last_ptr) ? '0 : rd_ptr_reg + PW'(1);

    // storage written on every parallel clock outside fifo reset
    always_ff @(posedge clk) begin
        if (!rx_fifo_rst) begin
            fifo_mem[wr_ptr_reg] <= rx_src_word;
        end
    end

    // pointer and read-side registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_reg      <= '0;
            rd_ptr_reg      <= '0;
            rd_run_reg      <= 1'b0;
            rx_fifo_out_reg <= '0;
            rx_data         <= '0;
            rx_data_valid   <= 1'b0;
        end else begin
            wr_ptr_reg    <= wr_ptr_next;
            rd_ptr_reg    <= rd_ptr_next;
            rd_run_reg    <= rd_go && !rx_fifo_rst;
            rx_data_valid <= rd_go && !rx_fifo_rst;
            if (rd_go && !rx_fifo_rst) begin
                rx_fifo_out_reg <= fifo_mem[rd_ptr_reg];
                rx_data         <= fifo_mem[rd_ptr_reg];
            end
        end
    end

endmodule : transceiver_loopback_bist

`default_nettype wire

// >>> line_side_model.sv
`default_nettype none

module line_side_model #(
    parameter int WORD_W = 20
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    output logic      [WORD_W-1:0] line_rx_word
);
    timeunit 1ns;
    timeprecision 1ps;

    // shared clock keeps both sides locked
    // counting words make any echo delay readable as a plain offset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_rx_word <= '0;
        end else begin
            line_rx_word <= line_rx_word + WORD_W'(1);
        end
    end
endmodule // line_side_model

`default_nettype wire

// >>> loopback_bist_checker.sv
`default_nettype none

module loopback_bist_checker #(
    parameter int WORD_W = 20
) (
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic [1:0]        func_mode,
    input wire logic              double_width,
    input wire logic [12:0]       line_rate_mbps,
    input wire logic [2:0]        lpbk_sel,
    input wire logic              serial_lpbk_en,
    input wire logic              rx_fifo_rst,
    input wire logic [WORD_W-1:0] line_rx_word,
    input wire logic [WORD_W-1:0] line_tx_word,
    input wire logic              rx_data_valid,
    input wire logic              bist_aligned,
    input wire logic              bist_error,
    input wire logic              cfg_illegal,
    input wire logic              rate_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // path legality, one cycle after the request
    a_serial_code_bad: assert property (lpbk_sel == 3'h1 |=> cfg_illegal)
        else $error("serial code not flagged");
    a_revp_pipe_only: assert property (
        lpbk_sel == 3'h5 && func_mode != 2'h1 |=> cfg_illegal)
        else $error("reverse parallel outside pipe not flagged");
    a_par_double_only: assert property (
        lpbk_sel == 3'h2 && !double_width |=> cfg_illegal)
        else $error("parallel in single width not flagged");
    a_par_basic_ok: assert property (
        lpbk_sel == 3'h2 && func_mode == 2'h0 && double_width
        && !serial_lpbk_en |=> !cfg_illegal)
        else $error("legal parallel loopback flagged");
    a_serial_no_pipe: assert property (
        serial_lpbk_en && func_mode == 2'h1 |=> cfg_illegal)
        else $error("serial loopback in pipe not flagged");

    // rate window per datapath width
    a_rate_single: assert property (func_mode == 2'h0 && !double_width
        |=> rate_error == ($past(line_rate_mbps) < 13'd600
        || $past(line_rate_mbps) > 13'd3125))
        else $error("single width rate check wrong");
    a_rate_double: assert property (func_mode == 2'h0 && double_width
        |=> rate_error == ($past(line_rate_mbps) < 13'd1000
        || $past(line_rate_mbps) > 13'd6375))
        else $error("double width rate check wrong");

    // reverse paths echo the line after a fixed delay
    a_rev_serial_echo: assert property (
        (lpbk_sel == 3'h3 && !serial_lpbk_en) [*3]
        |-> line_tx_word == $past(line_rx_word, 2))
        else $error("reverse serial echo wrong");
    a_precdr_echo: assert property (
        (lpbk_sel == 3'h4 && !serial_lpbk_en) [*2]
        |-> line_tx_word == $past(line_rx_word))
        else $error("pre-cdr echo wrong");

    a_error_after_lock: assert property (bist_error |-> $past(bist_aligned))
        else $error("error reported without lock");

    // fifo start-up and steady reading
    a_fifo_starts: assert property ($fell(rx_fifo_rst) |-> ##[1:8] rx_data_valid)
        else $error("fifo did not start");
    a_fifo_keeps: assert property (
        rx_data_valid && !rx_fifo_rst |=> rx_data_valid)
        else $error("fifo stream stopped");
    a_fifo_fills_first: assert property ($rose(rx_data_valid)
        |-> !$past(rx_fifo_rst) && !$past(rx_fifo_rst, 2))
        else $error("fifo read before fill");

    c_aligned: cover property (bist_aligned);
    c_valid: cover property (rx_data_valid);
    c_illegal: cover property (cfg_illegal);
endmodule // loopback_bist_checker

bind transceiver_loopback_bist loopback_bist_checker #(.WORD_W(WORD_W))
    u_loopback_bist_checker (.clk(clk), .resetn(resetn),
    .func_mode(func_mode), .double_width(double_width),
    .line_rate_mbps(line_rate_mbps), .lpbk_sel(lpbk_sel),
    .serial_lpbk_en(serial_lpbk_en), .rx_fifo_rst(rx_fifo_rst),
    .line_rx_word(line_rx_word), .line_tx_word(line_tx_word),
    .rx_data_valid(rx_data_valid), .bist_aligned(bist_aligned),
    .bist_error(bist_error), .cfg_illegal(cfg_illegal),
    .rate_error(rate_error));

`default_nettype wire

// >>> transceiver_loopback_bist_tb.sv
`default_nettype none

module transceiver_loopback_bist_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 20;
    logic          clk, resetn, double_width, serial_lpbk_en;
    logic          bist_en, prbs_sel, rx_fifo_rst, rx_data_valid;
    logic          bist_aligned, bist_error, cfg_illegal, rate_error;
    logic [1:0]    func_mode;
    logic [2:0]    lpbk_sel;
    logic [12:0]   line_rate_mbps;
    logic [W-1:0]  tx_data, line_rx_word, line_tx_word, rx_data;
    int            mismatches = 0;
    int            n_compared = 0;

    // {mode, double, path, serial pin, flagged}
    logic [7:0] cfg_tab [12] = '{8'h20, 8'h25, 8'h28, 8'h09, 8'h2c, 8'h30,
        8'h35, 8'h74, 8'h63, 8'h82, 8'ha9, 8'h22};
    // {double, flagged, 0, rate}
    logic [15:0] rate_tab [8] = '{16'h4257, 16'h0258, 16'h0c35, 16'h4c36,
        16'hc3e7, 16'h83e8, 16'h98e7, 16'hd8e8};

    transceiver_loopback_bist #(.WORD_W(W)) u_transceiver_loopback_bist (
        .clk(clk), .resetn(resetn), .func_mode(func_mode),
        .double_width(double_width), .line_rate_mbps(line_rate_mbps),
        .lpbk_sel(lpbk_sel), .serial_lpbk_en(serial_lpbk_en),
        .bist_en(bist_en), .prbs_sel(prbs_sel), .rx_fifo_rst(rx_fifo_rst),
        .tx_data(tx_data), .line_rx_word(line_rx_word),
        .line_tx_word(line_tx_word), .rx_data(rx_data),
        .rx_data_valid(rx_data_valid), .bist_aligned(bist_aligned),
        .bist_error(bist_error), .cfg_illegal(cfg_illegal),
        .rate_error(rate_error));
    line_side_model #(.WORD_W(W)) u_line_side_model (.clk(clk),
        .resetn(resetn), .line_rx_word(line_rx_word));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [W-1:0] exp,
                         input logic [W-1:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bit 0 of the older word is first in time
    function automatic logic seq_ok(input logic [2*W-1:0] s, input logic p);
        logic ok;
        ok = 1'b1;
        for (int k = 10; k < 2*W; k++) begin
            if (p) ok &= (s[k] === (s[k-7] ^ s[k-10]));
            else ok &= (s[k] === (s[k-6] ^ s[k-7]));
        end
        return ok;
    endfunction

    task automatic set_cfg(input logic [1:0] m, input logic d,
                           input logic [2:0] s, input logic e);
        @(posedge clk);
        func_mode <= m;
        double_width <= d;
        lpbk_sel <= s;
        serial_lpbk_en <= e;
    endtask

    task automatic test_cfg();
        for (int i = 0; i < 12; i++) begin
            set_cfg(cfg_tab[i][7:6], cfg_tab[i][5], cfg_tab[i][4:2],
                    cfg_tab[i][1]);
            tick(2);
            check("cfg_illegal", W'(cfg_tab[i][0]), W'(cfg_illegal));
        end
    endtask

    task automatic test_rate();
        for (int i = 0; i < 8; i++) begin
            set_cfg(2'h0, rate_tab[i][15], 3'h0, 1'b0);
            line_rate_mbps <= rate_tab[i][12:0];
            tick(2);
            check("rate_error", W'(rate_tab[i][14]), W'(rate_error));
        end
    endtask

    // mode changes only while the fifo is held in reset
    task automatic test_fifo();
        int lat [2];
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            rx_fifo_rst <= 1'b1;
            func_mode <= 2'(m);
            repeat (2) @(posedge clk);
            rx_fifo_rst <= 1'b0;
            lat[m] = 0;
            while (rx_data_valid !== 1'b1 && lat[m] < 20) begin
                tick(1);
                lat[m]++;
            end
            repeat (8) begin
                tick(1);
                check("rx_data_valid", W'(1), W'(rx_data_valid));
            end
        end
        check("depth latency gap", W'(2), W'(lat[1] - lat[0]));
    endtask

    task automatic test_rev();
        for (int o = 1; o < 3; o++) begin
            set_cfg(2'h0, 1'b1, (o == 2) ? 3'h3 : 3'h4, 1'b0);
            tick(4);
            check("reverse echo", line_rx_word - W'(o), line_tx_word);
        end
    endtask

    // generator and verifier, parallel path then serial with bist
    task automatic test_prbs();
        logic [W-1:0] w1;
        int n;
        for (int i = 0; i < 4; i++) begin
            set_cfg(2'h0, 1'b1, 3'h0, 1'b0);
            tick(3);
            check("bist_aligned off", W'(0), W'(bist_aligned));
            set_cfg(2'h0, 1'b1, i[1] ? 3'h0 : 3'h2, i[1]);
            bist_en <= i[1];
            prbs_sel <= i[0];
            n = 0;
            while (bist_aligned !== 1'b1 && n < 30) begin
                tick(1);
                n++;
            end
            check("bist_aligned", W'(1), W'(bist_aligned));
            w1 = line_tx_word;
            tick(1);
            check("prbs order", W'(1), W'(seq_ok({line_tx_word, w1}, i[0])));
            repeat (8) begin
                tick(1);
                check("bist_error", W'(0), W'(bist_error));
            end
        end
    endtask

    task automatic test_serial_fabric();
        set_cfg(2'h0, 1'b1, 3'h0, 1'b1);
        bist_en <= 1'b0;
        tx_data <= 20'h5a5a5;
        tick(3);
        check("line_tx_word", 20'h5a5a5, line_tx_word);
        tick(12);
        check("rx_data", 20'h5a5a5, rx_data);
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // run takes about 200 cycles; this is a wide margin
    initial begin
        #(40 * 5000);
        mismatches++;
        print_verdict();
    end

    initial begin
        {resetn, double_width, serial_lpbk_en, bist_en, prbs_sel} = '0;
        {func_mode, lpbk_sel, tx_data} = '0;
        rx_fifo_rst = 1'b1;
        line_rate_mbps = 13'd2000;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        test_cfg();
        test_rate();
        test_fifo();
        test_rev();
        test_prbs();
        test_serial_fabric();
        print_verdict();
    end
endmodule // transceiver_loopback_bist_tb

`default_nettype wire
